// File: rtl/pci_consts.svh
// pin-change interrupt constants: register indices, resets, timing
// assumes the apb byte address of a register is four times its index
`ifndef PCI_CONSTS_SVH
`define PCI_CONSTS_SVH
`define PCI_IDX_MASK0 8'h6b
`define PCI_IDX_MASK1 8'h6c
`define PCI_IDX_MASK2 8'h6d
`define PCI_IDX_MASK3 8'h73
`define PCI_IDX_ENABLE 8'h68
`define PCI_IDX_FLAGS 8'h69
`define PCI_IDX_LEVEL 8'h6a
`define PCI_MASK_RST 8'h00
`define PCI_ENABLE_RST 4'h0
`define PCI_ARM_CYCLES 2'h3
`endif

// File: rtl/pci_grp.sv
// one group of eight change-sense pins with its sticky request flag
// assumes raw pins are asynchronous; mask and enable come from the core clock
`include "pci_consts.svh"
`default_nettype none
module pci_grp
    import pci_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_pins,
    input wire logic [7:0] i_mask,
    input wire logic i_enable,
    input wire logic i_clear,
    output logic [7:0] o_level,
    output pci_grp_stat_t o_stat
);
    logic [7:0] sync1_ff;
    logic [7:0] sync2_ff;
    logic [7:0] prev_ff;
    logic [1:0] arm_ff;
    logic flag_ff;
    logic armed;
    logic [7:0] hit;
    logic change;
    logic nxt_flag;
    ////////////////////////////////////////////////////////////////////////
    // detection on the free-running core clock, not the gated i/o clock
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            sync1_ff <= 8'h00;
            sync2_ff <= 8'h00;
            prev_ff <= 8'h00;
        end else begin
            sync1_ff <= i_pins;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end
    // hold off detection until the pipe holds real pin levels
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            arm_ff <= 2'h0;
        end else if (!armed) begin
            arm_ff <= arm_ff + 2'h1;
        end
    end
    // per-pin gating by its mask bit and the group enable
    assign armed = (arm_ff == `PCI_ARM_CYCLES);
    assign hit = (sync2_ff ^ prev_ff) & i_mask & {8{i_enable}};
    assign change = armed & (|hit);
    // a new change wins over a clear in the same cycle
    assign nxt_flag = change | (flag_ff & ~i_clear);
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end
    assign o_level = sync2_ff;
    assign o_stat = '{flag: flag_ff, change: change};
    ////////////////////////////////////////////////////////////////////////
    property p_flag_set;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        change |=> flag_ff;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("change lost");
    property p_clear;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_clear && !change) |=> !flag_ff;
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");
    property p_masked_off;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        ((sync2_ff ^ prev_ff) & i_mask) == 8'h00 |-> !change;
    endproperty
    a_masked_off: assert property (p_masked_off) else $error("masked pin set");
    property p_group_off;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        !i_enable && !flag_ff && !change |=> !flag_ff;
    endproperty
    a_group_off: assert property (p_group_off) else $error("disabled set");
endmodule : pci_grp
`default_nettype wire

// File: rtl/pci_pkg.sv
// types shared by the pin-change interrupt block
// assumes a single 250 mhz core clock
`default_nettype none
package pci_pkg;
    // apb phase tracker, one-hot
    typedef enum logic [2:0] {
        pci_st_idle = 3'b001,
        pci_st_setup = 3'b010,
        pci_st_access = 3'b100
    } pci_apb_st_t;
    // apb request as seen by the slave
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } pci_apb_req_t;
    // per-group state handed up to the top
    typedef struct packed {
        logic flag;
        logic change;
    } pci_grp_stat_t;
endpackage : pci_pkg
`default_nettype wire

// File: rtl/pci_top.sv
// pin-change interrupt controller: 32 pins in four groups of eight
// apb slave for masks, enables, flags and pin levels
// assumes a zero-wait apb master and a core that acks each vector it takes
//
// The APB slave port is this design's own decision.
`include "pci_consts.svh"
`default_nettype none
module pci_top
    import pci_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [31:0] i_change_sense_pins,
    input wire logic i_global_int_en,
    input wire logic [3:0] i_vector_taken,
    output logic [3:0] o_group_vector_req,
    output logic o_irq,
    output logic o_wake
);
    ////////////////////////////////////////////////////////////////////////
    // declarations
    pci_apb_req_t req;
    pci_apb_st_t state_ff;
    pci_apb_st_t nxt_state;
    logic [7:0] mask_ff [4];
    logic [3:0] enable_ff;
    logic [31:0] prdata_ff;
    logic [31:0] rd_mux;
    logic [31:0] level;
    logic [3:0] flags;
    logic [3:0] changes;
    logic [3:0] clr;
    logic [3:0] pending;
    pci_grp_stat_t stat [4];
    logic setup_cyc;
    logic acc_cyc;
    logic wr_en;
    logic hit_mask0;
    logic hit_mask1;
    logic hit_mask2;
    logic hit_mask3;
    logic hit_enable;
    logic hit_flags;
    logic hit_level;
    logic hit_any;
    logic word_ok;
    logic [7:0] idx;
    ////////////////////////////////////////////////////////////////////////
    // bundle the apb inputs; they come from logic on the same clock
    assign req = '{
        sel: i_psel,
        enable: i_penable,
        write: i_pwrite,
        addr: i_paddr,
        wdata: i_pwdata
    };
    assign setup_cyc = req.sel & ~req.enable;
    assign acc_cyc = req.sel & req.enable;
    ////////////////////////////////////////////////////////////////////////
    // apb phase tracker; an access without a setup before it is not answered
    always_comb begin
        nxt_state = pci_st_idle;
        case (state_ff)
            pci_st_idle: begin
                if (setup_cyc) begin
                    nxt_state = pci_st_setup;
                end
            end
            pci_st_setup: begin
                if (acc_cyc) begin
                    nxt_state = pci_st_access;
                end else if (setup_cyc) begin
                    nxt_state = pci_st_setup;
                end
            end
            pci_st_access: begin
                if (setup_cyc) begin
                    nxt_state = pci_st_setup;
                end
            end
            default: begin
                nxt_state = pci_st_idle;
            end
        endcase
    end
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state_ff <= pci_st_idle;
        end else begin
            state_ff <= nxt_state;
        end
    end
    // zero wait: the first access cycle after a setup completes
    assign o_pready = acc_cyc & (state_ff == pci_st_setup);
    assign wr_en = o_pready & req.write;
    ////////////////////////////////////////////////////////////////////////
    // address decode; printed offsets are word indices, not byte addresses
    assign idx = req.addr[9:2];
    assign word_ok = (req.addr[11:10] == 2'h0) && (req.addr[1:0] == 2'h0);
    assign hit_mask0 = word_ok && (idx == `PCI_IDX_MASK0);
    assign hit_mask1 = word_ok && (idx == `PCI_IDX_MASK1);
    assign hit_mask2 = word_ok && (idx == `PCI_IDX_MASK2);
    assign hit_mask3 = word_ok && (idx == `PCI_IDX_MASK3);
    assign hit_enable = word_ok && (idx == `PCI_IDX_ENABLE);
    assign hit_flags = word_ok && (idx == `PCI_IDX_FLAGS);
    assign hit_level = word_ok && (idx == `PCI_IDX_LEVEL);
    assign hit_any = hit_mask0 | hit_mask1 | hit_mask2 | hit_mask3 |
                     hit_enable | hit_flags | hit_level;
    // unmapped addresses answer with an error, writes to them are dropped
    assign o_pslverr = o_pready & ~hit_any;
    ////////////////////////////////////////////////////////////////////////
    // read mux; narrow registers sit in the low bits, upper bits read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_mask0) begin
            rd_mux = {24'h00_0000, mask_ff[0]};
        end else if (hit_mask1) begin
            rd_mux = {24'h00_0000, mask_ff[1]};
        end else if (hit_mask2) begin
            rd_mux = {24'h00_0000, mask_ff[2]};
        end else if (hit_mask3) begin
            rd_mux = {24'h00_0000, mask_ff[3]};
        end else if (hit_enable) begin
            rd_mux = {28'h000_0000, enable_ff};
        end else if (hit_flags) begin
            rd_mux = {28'h000_0000, flags};
        end else if (hit_level) begin
            rd_mux = level;
        end
    end
    // read data is captured in the setup cycle so prdata comes from a flop
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            prdata_ff <= 32'h0000_0000;
        end else if (setup_cyc) begin
            prdata_ff <= rd_mux;
        end
    end
    assign o_prdata = prdata_ff;
    ////////////////////////////////////////////////////////////////////////
    // mask registers, one per group, plain read/write
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            mask_ff[0] <= `PCI_MASK_RST;
            mask_ff[1] <= `PCI_MASK_RST;
            mask_ff[2] <= `PCI_MASK_RST;
            mask_ff[3] <= `PCI_MASK_RST;
        end else if (wr_en) begin
            if (hit_mask0) begin
                mask_ff[0] <= req.wdata[7:0];
            end else if (hit_mask1) begin
                mask_ff[1] <= req.wdata[7:0];
            end else if (hit_mask2) begin
                mask_ff[2] <= req.wdata[7:0];
            end else if (hit_mask3) begin
                mask_ff[3] <= req.wdata[7:0];
            end
        end
    end
    // group enables double as the interrupt mask over the flag bits
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            enable_ff <= `PCI_ENABLE_RST;
        end else if (wr_en && hit_enable) begin
            enable_ff <= req.wdata[3:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // flag clears: a one written, or the core taking that vector
    assign clr = ({4{wr_en & hit_flags}} & req.wdata[3:0]) | i_vector_taken;
    // four identical groups; group n uses mask n and enable bit n
    generate
        for (genvar g = 0; g < 4; g++) begin : g_grp
            pci_grp u_grp (
                .i_core_clk(i_core_clk),
                .i_sys_rst(i_sys_rst),
                .i_pins(i_change_sense_pins[8*g +: 8]),
                .i_mask(mask_ff[g]),
                .i_enable(enable_ff[g]),
                .i_clear(clr[g]),
                .o_level(level[8*g +: 8]),
                .o_stat(stat[g])
            );
            assign flags[g] = stat[g].flag;
            assign changes[g] = stat[g].change;
        end
    endgenerate
    ////////////////////////////////////////////////////////////////////////
    // vector requests need the flag, the group enable and the global bit
    assign pending = flags & enable_ff;
    assign o_group_vector_req = pending & {4{i_global_int_en}};
    assign o_irq = |o_group_vector_req;
    // wake ignores the global bit so a sleeping core still sees the change
    assign o_wake = |pending;
    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_vec_g2;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (flags[2] && enable_ff[2] && i_global_int_en) |-> o_group_vector_req[2];
    endproperty
    a_vec_g2: assert property (p_vec_g2) else $error("group 2 not requested");
    property p_vec_g1;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        !(enable_ff[1] && i_global_int_en) |-> !o_group_vector_req[1];
    endproperty
    a_vec_g1: assert property (p_vec_g1) else $error("group 1 unqualified");
    property p_vec_g0;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (changes[0] && enable_ff[0] && i_global_int_en && !clr[0])
            |=> o_group_vector_req[0] && flags[0];
    endproperty
    a_vec_g0: assert property (p_vec_g0) else $error("group 0 not raised");
    property p_vec_g3;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        o_group_vector_req[3] |-> flags[3] && enable_ff[3] && i_global_int_en;
    endproperty
    a_vec_g3: assert property (p_vec_g3) else $error("group 3 unqualified");
    property p_g3_gate;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        !enable_ff[3] |-> !changes[3];
    endproperty
    a_g3_gate: assert property (p_g3_gate) else $error("group 3 ungated");
    property p_taken;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_vector_taken[1] && !changes[1]) |=> !flags[1] && !o_group_vector_req[1];
    endproperty
    a_taken: assert property (p_taken) else $error("taken flag kept");
    property p_w1c;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (wr_en && hit_flags && req.wdata[2] && !changes[2]) |=> !flags[2];
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one kept flag");
    property p_w0;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (wr_en && hit_flags && !req.wdata[0] && flags[0] && !i_vector_taken[0])
            |=> flags[0];
    endproperty
    a_w0: assert property (p_w0) else $error("write zero cleared flag");
    property p_mask3_wr;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (wr_en && hit_mask3) |=> mask_ff[3] == $past(req.wdata[7:0]);
    endproperty
    a_mask3_wr: assert property (p_mask3_wr) else $error("mask 3 not written");
    property p_mask2_rd;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (setup_cyc && hit_mask2) |=> o_prdata == {24'h00_0000, $past(mask_ff[2])};
    endproperty
    a_mask2_rd: assert property (p_mask2_rd) else $error("mask 2 read wrong");
    property p_mask1_hold;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        !(wr_en && hit_mask1) |=> $stable(mask_ff[1]);
    endproperty
    a_mask1_hold: assert property (p_mask1_hold) else $error("mask 1 drifted");
    property p_mask0_rst;
        @(posedge i_core_clk)
        i_sys_rst |=> mask_ff[0] == `PCI_MASK_RST;
    endproperty
    a_mask0_rst: assert property (p_mask0_rst) else $error("mask 0 reset");
    property p_wake;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (changes[1] && enable_ff[1] && !clr[1]) |=> o_wake;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on change");
    property p_ready;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        setup_cyc ##1 acc_cyc |-> o_pready;
    endproperty
    a_ready: assert property (p_ready) else $error("apb not answered");
    ////////////////////////////////////////////////////////////////////////
    // the other half of each gate, plus bus and reset behaviour
    property p_vec_g2_off;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        !(enable_ff[2] && i_global_int_en) |-> !o_group_vector_req[2];
    endproperty
    a_vec_g2_off: assert property (p_vec_g2_off) else $error("group 2 ungated");
    property p_vec_g1_on;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (flags[1] && enable_ff[1] && i_global_int_en) |-> o_group_vector_req[1];
    endproperty
    a_vec_g1_on: assert property (p_vec_g1_on) else $error("group 1 not requested");
    property p_vec_g0_off;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        !(enable_ff[0] && i_global_int_en) |-> !o_group_vector_req[0];
    endproperty
    a_vec_g0_off: assert property (p_vec_g0_off) else $error("group 0 ungated");
    property p_vec_g3_on;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (flags[3] && enable_ff[3] && i_global_int_en) |-> o_group_vector_req[3];
    endproperty
    a_vec_g3_on: assert property (p_vec_g3_on) else $error("group 3 not requested");
    property p_irq_level;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        o_irq == ((|(flags & enable_ff)) && i_global_int_en);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq level wrong");
    property p_flag_sticky;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (flags[2] && !clr[2]) |=> flags[2];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag 2 dropped");
    property p_flags_rst;
        @(posedge i_core_clk)
        i_sys_rst |=> (flags == 4'h0) && !o_wake;
    endproperty
    a_flags_rst: assert property (p_flags_rst) else $error("flags not reset");
    property p_enable_wr;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (wr_en && hit_enable) |=> enable_ff == $past(req.wdata[3:0]);
    endproperty
    a_enable_wr: assert property (p_enable_wr) else $error("enable not written");
    property p_err_drop;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (o_pslverr && req.write) |=> $stable(enable_ff) && $stable(mask_ff[0]);
    endproperty
    a_err_drop: assert property (p_err_drop) else $error("errored write landed");
    property p_err_ready;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        o_pslverr |-> o_pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_no_orphan;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (acc_cyc && state_ff != pci_st_setup) |-> !o_pready;
    endproperty
    a_no_orphan: assert property (p_no_orphan) else $error("access without setup");
    property p_taken_g3;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_vector_taken[3] && !changes[3]) |=> !flags[3];
    endproperty
    a_taken_g3: assert property (p_taken_g3) else $error("taken flag 3 kept");
    c_irq: cover property (@(posedge i_core_clk) disable iff (i_sys_rst) $rose(o_irq));
    c_taken: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
        i_vector_taken[0] && flags[0]);
    c_w1c: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
        wr_en && hit_flags && (req.wdata[3:0] & flags) != 4'h0);
    c_err: cover property (@(posedge i_core_clk) disable iff (i_sys_rst) o_pslverr);
    c_wake: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
        o_wake && !i_global_int_en);
endmodule : pci_top
`default_nettype wire

// File: test/pci_pin_model.sv
// model of the external lines that drive the change-sense pins
// assumes flip requests come as one-cycle pulses on the core clock
`default_nettype none
module pci_pin_model (
    input wire logic i_core_clk,
    input wire logic [31:0] i_flip,
    output logic [31:0] o_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////////////
    // lines start low and are always driven, so no floating level reaches the sync
    initial o_pins = 32'h0;
    // a flip request inverts the chosen lines one edge later
    always @(posedge i_core_clk) begin
        o_pins <= o_pins ^ i_flip;
    end
endmodule : pci_pin_model
`default_nettype wire

// File: test/pin_change_interrupt_tb.sv
// self-checking bench for the pin-change interrupt block
// assumes a zero-wait apb slave at byte address four times the register index
`include "pci_consts.svh"
`default_nettype none
module pin_change_interrupt_tb;
    import pci_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, psel, pen, pwr, pslverr, pready, glob, irq, wake;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, pins, flip, lfsr, rd;
    logic [3:0] taken, vreq;
    logic err;
    int error_cnt, n_checks, cycles;
    logic [7:0] midx [4] = '{`PCI_IDX_MASK0, `PCI_IDX_MASK1, `PCI_IDX_MASK2, `PCI_IDX_MASK3};
    ////////////////////////////////////////////////////////////////////////////////
    pci_top pci_top_i (.i_core_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_change_sense_pins(pins),
        .i_global_int_en(glob), .i_vector_taken(taken), .o_group_vector_req(vreq),
        .o_irq(irq), .o_wake(wake));
    pci_pin_model pci_pin_model_i (.i_core_clk(clk), .i_flip(flip), .o_pins(pins));
    ////////////////////////////////////////////////////////////////////////////////
    // expected request lines: flag, enable and global bit all needed
    function automatic logic [3:0] exp_vec(logic [3:0] f, logic [3:0] e, logic g);
        return f & e & {4{g}};
    endfunction : exp_vec
    function automatic logic [11:0] adr(logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction : adr
    function automatic logic [31:0] lfsr_next(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    task automatic chk(logic [31:0] seen, logic [31:0] exp, string msg);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask : chk
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    // one apb transfer: setup, then hold until pready is seen high at an edge
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk(1'b0, 1'b1, "apb wait");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    // toggle pins then leave time for sync and flag latency
    task automatic toggle(logic [31:0] m);
        @(posedge clk);
        flip <= m;
        @(posedge clk);
        flip <= 32'h0;
        repeat (6) @(posedge clk);
    endtask : toggle
    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [2:0] b;
        error_cnt = 0;
        n_checks = 0;
        cycles = 0;
        {psel, pen, pwr, paddr, pwdata, flip, taken} = '0;
        rst = 1'b1;
        glob = 1'b1;
        lfsr = 32'h02f7;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        chk(irq, 1'b0, "irq after reset");
        // reset values of masks, then random write and read back
        for (int g = 0; g < 4; g++) begin
            apb(1'b0, adr(midx[g]), 32'h0);
            chk(rd, 32'h0, "mask reset");
            lfsr = lfsr_next(lfsr);
            apb(1'b1, adr(midx[g]), lfsr);
            apb(1'b0, adr(midx[g]), 32'h0);
            chk(rd, {24'h0, lfsr[7:0]}, "mask readback");
            apb(1'b1, adr(midx[g]), 32'h0);
        end
        apb(1'b0, adr(`PCI_IDX_FLAGS), 32'h0);
        chk(rd, 32'h0, "flags reset");
        chk(err, 1'b0, "mapped read error");
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0, "unmapped read data");
        chk(err, 1'b1, "unmapped read error");
        // per group: masked-out pin, masked-in pin, global gate, clears, disabled group
        for (int g = 0; g < 4; g++) begin
            lfsr = lfsr_next(lfsr);
            b = lfsr[2:0];
            apb(1'b1, adr(midx[g]), 32'h1 << b);
            apb(1'b1, adr(`PCI_IDX_ENABLE), 32'h1 << g);
            toggle(32'h1 << (8 * g + ((b + 1) % 8)));
            apb(1'b0, adr(`PCI_IDX_FLAGS), 32'h0);
            chk(rd, 32'h0, "masked-out pin");
            toggle(32'h1 << (8 * g + b));
            chk(vreq, exp_vec(4'h1 << g, 4'h1 << g, 1'b1), "vector req");
            chk(irq, 1'b1, "irq level");
            apb(1'b0, adr(`PCI_IDX_FLAGS), 32'h0);
            chk(rd, 32'h1 << g, "flag set");
            glob <= 1'b0;
            repeat (2) @(posedge clk);
            chk(vreq, exp_vec(4'h1 << g, 4'h1 << g, 1'b0), "global off");
            chk(wake, 1'b1, "wake held");
            chk(irq, 1'b0, "irq gated");
            glob <= 1'b1;
            apb(1'b1, adr(`PCI_IDX_FLAGS), 32'h0);
            apb(1'b0, adr(`PCI_IDX_FLAGS), 32'h0);
            chk(rd, 32'h1 << g, "write zero keeps flag");
            apb(1'b1, adr(`PCI_IDX_FLAGS), 32'h1 << g);
            apb(1'b0, adr(`PCI_IDX_FLAGS), 32'h0);
            chk(rd, 32'h0, "write one clears flag");
            toggle(32'h1 << (8 * g + b));
            @(posedge clk);
            taken <= 4'h1 << g;
            @(posedge clk);
            taken <= 4'h0;
            repeat (2) @(posedge clk);
            chk(vreq, 4'h0, "vector taken");
            apb(1'b1, adr(`PCI_IDX_ENABLE), 32'h0);
            toggle(32'h1 << (8 * g + b));
            apb(1'b0, adr(`PCI_IDX_FLAGS), 32'h0);
            chk(rd, 32'h0, "group disabled");
            apb(1'b0, adr(`PCI_IDX_LEVEL), 32'h0);
            chk(rd, pins, "pin level");
            apb(1'b1, adr(midx[g]), 32'h0);
        end
        conclude();
    end
endmodule : pin_change_interrupt_tb
`default_nettype wire
